// [uart_fc.sv]
`include "uart_fc_defs.svh"
module uart_fc
  import uart_fc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [31:0] i_pin,
  output logic [31:0] o_pin,
  output logic [31:0] o_pin_oen
);
  // ==========================================================
  // apb slave
  logic pready_q, pslverr_q, known;
  logic [31:0] prdata_q, rdata;
  logic setup, acc, wr, rd;
  assign setup = i_psel & ~i_penable;
  assign acc = i_psel & i_penable & pready_q;
  assign wr = acc & i_pwrite;
  assign rd = acc & ~i_pwrite;
  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;

  logic [2:0] enable_q, cfg_par_q;
  logic cfg_hwfc_q;
  logic [31:0] baud_q, psel_rts_q, psel_tx_q, psel_cts_q, psel_rx_q;
  logic ev_txdone_q, ev_rxrdy_q, ev_err_q, ev_receiver_timeout_event_q;
  err_s err_q, err_set;
  logic en, par_on;
  assign en = enable_q == `ENABLE_ON;
  assign par_on = cfg_par_q == `PARITY_ON;

  logic [7:0] rx_mem [0:`RX_DEPTH-1];
  logic [2:0] rx_wp_q, rx_rp_q, rx_cnt_q;

  // read mux, looked up in the setup cycle so data is ready with pready
  always_comb begin
    rdata = 32'h0;
    known = 1'b1;
    case (i_paddr)
      `OFF_BEGIN_RX, `OFF_HALT_RX, `OFF_BEGIN_TX, `OFF_HALT_TX, `OFF_TX_DATA: rdata = 32'h0;
      `OFF_EV_RXRDY: rdata = {31'h0, ev_rxrdy_q};
      `OFF_EV_TXDONE: rdata = {31'h0, ev_txdone_q};
      `OFF_EV_ERROR: rdata = {31'h0, ev_err_q};
      `OFF_EV_RECEIVER_TIMEOUT_EVENT: rdata = {31'h0, ev_receiver_timeout_event_q};
      `OFF_ERRSRC: rdata = {28'h0, err_q};
      `OFF_ENABLE: rdata = {29'h0, enable_q};
      `OFF_PSEL_RTS: rdata = psel_rts_q;
      `OFF_PSEL_TX: rdata = psel_tx_q;
      `OFF_PSEL_CTS: rdata = psel_cts_q;
      `OFF_PSEL_RX: rdata = psel_rx_q;
      `OFF_RX_DATA: rdata = {24'h0, rx_mem[rx_rp_q]};
      `OFF_BAUD: rdata = baud_q;
      `OFF_CONFIG: rdata = {28'h0, cfg_par_q, cfg_hwfc_q};
      default: known = 1'b0;
    endcase
  end

  // zero-wait answer: pready rises in the access cycle
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup & ~pready_q;
      pslverr_q <= setup & ~pready_q & ~known;
      if (setup) begin
        prdata_q <= rdata;
      end
    end
  end

  // configuration registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      enable_q <= 3'h0;
      cfg_hwfc_q <= 1'b0;
      cfg_par_q <= 3'h0;
      baud_q <= `BAUD_RESET;
      psel_rts_q <= `PSEL_RESET;
      psel_tx_q <= `PSEL_RESET;
      psel_cts_q <= `PSEL_RESET;
      psel_rx_q <= `PSEL_RESET;
    end else if (wr) begin
      case (i_paddr)
        `OFF_ENABLE: enable_q <= i_pwdata[2:0];
        `OFF_CONFIG: {cfg_par_q, cfg_hwfc_q} <= i_pwdata[3:0];
        `OFF_BAUD: baud_q <= i_pwdata;
        `OFF_PSEL_RTS: psel_rts_q <= i_pwdata;
        `OFF_PSEL_TX: psel_tx_q <= i_pwdata;
        `OFF_PSEL_CTS: psel_cts_q <= i_pwdata;
        `OFF_PSEL_RX: psel_rx_q <= i_pwdata;
        default: ;
      endcase
    end
  end

  logic t_brx, t_hrx, t_btx, t_htx, tx_wr;
  assign t_brx = wr & (i_paddr == `OFF_BEGIN_RX) & i_pwdata[0];
  assign t_hrx = wr & (i_paddr == `OFF_HALT_RX) & i_pwdata[0];
  assign t_btx = wr & (i_paddr == `OFF_BEGIN_TX) & i_pwdata[0];
  assign t_htx = wr & (i_paddr == `OFF_HALT_TX) & i_pwdata[0];
  assign tx_wr = wr & (i_paddr == `OFF_TX_DATA);

  // ==========================================================
  // baud generator: phase accumulator giving a 16x oversample tick
  logic [31:0] phase_q, inc16;
  logic [47:0] prod;
  logic [32:0] sum;
  logic tick;
  assign prod = baud_q * `BAUD_SCALE; // scale 16 MHz reference to the 40 MHz clock
  assign inc16 = {prod[43:16], 4'h0};
  assign sum = {1'b0, phase_q} + {1'b0, inc16};
  assign tick = sum[32];
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_q <= 32'h0;
    end else begin
      phase_q <= sum[31:0];
    end
  end

  // ==========================================================
  // pins: two-stage synchroniser, then routing by pin select
  logic [31:0] sync1_q, sync2_q, pin_q, oen_q;
  logic rx_in, cts_n, tx_line_q, rts_n_q;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_q <= 32'hFFFFFFFF;
      sync2_q <= 32'hFFFFFFFF;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
    end
  end
  // unrouted receive idles high; unrouted clear-to-send reads as active
  assign rx_in = (en && psel_rx_q[31:5] == 27'h0) ? sync2_q[psel_rx_q[4:0]] : 1'b1;
  assign cts_n = (en && psel_cts_q[31:5] == 27'h0) ? sync2_q[psel_cts_q[4:0]] : 1'b0;

  // an all-ones select never equals a pin index, so it drives nothing
  for (genvar g = 0; g < 32; g++) begin : g_pin
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        pin_q[g] <= 1'b1;
        oen_q[g] <= 1'b1;
      end else if (en && psel_tx_q == g) begin
        pin_q[g] <= tx_line_q;
        oen_q[g] <= 1'b0;
      end else if (en && psel_rts_q == g) begin
        pin_q[g] <= rts_n_q;
        oen_q[g] <= 1'b0;
      end else begin
        pin_q[g] <= 1'b1;
        oen_q[g] <= 1'b1;
      end
    end
  end
  assign o_pin = pin_q;
  assign o_pin_oen = oen_q;

  // ==========================================================
  // transmitter
  tx_state_e tx_st_q;
  logic tx_run_q, tx_pend_q, tx_par_q, cts_ok, tx_go, tx_bend;
  logic [7:0] tx_buf_q, tx_sh_q;
  logic [2:0] tx_bit_q;
  logic [3:0] tx_ovs_q;
  assign cts_ok = ~cfg_hwfc_q | ~cts_n;
  // flow control is looked at only between frames, so a byte in flight completes
  assign tx_go = tx_run_q & tx_pend_q & cts_ok;
  assign tx_bend = tick & (tx_ovs_q == 4'hF);

  // run flag and single-entry holding register
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_run_q <= 1'b0;
      tx_pend_q <= 1'b0;
      tx_buf_q <= 8'h0;
    end else begin
      tx_run_q <= (tx_run_q | t_btx) & ~t_htx;
      tx_pend_q <= tx_wr | (tx_pend_q & ~(tx_st_q == TX_IDLE && tx_go) & ~t_htx);
      if (tx_wr) begin
        tx_buf_q <= i_pwdata[7:0];
      end
    end
  end

  // frame sequencer; halt drops the frame on the spot
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_st_q <= TX_IDLE;
      tx_line_q <= 1'b1;
      tx_sh_q <= 8'h0;
      tx_bit_q <= 3'h0;
      tx_ovs_q <= 4'h0;
      tx_par_q <= 1'b0;
    end else if (t_htx) begin
      tx_st_q <= TX_IDLE;
      tx_line_q <= 1'b1;
    end else begin
      if (tick) begin
        tx_ovs_q <= tx_ovs_q + 4'h1;
      end
      case (tx_st_q)
        TX_IDLE: if (tx_go) begin
          tx_st_q <= TX_START;
          tx_line_q <= 1'b0;
          tx_ovs_q <= 4'h0;
          tx_sh_q <= tx_buf_q;
          tx_par_q <= ^tx_buf_q; // even parity
        end
        TX_START: if (tx_bend) begin
          tx_st_q <= TX_DATA;
          tx_line_q <= tx_sh_q[0];
          tx_bit_q <= 3'h0;
        end
        TX_DATA: if (tx_bend) begin
          if (tx_bit_q == 3'h7) begin
            tx_st_q <= par_on ? TX_PAR : TX_STOP;
            tx_line_q <= par_on ? tx_par_q : 1'b1;
          end else begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]}; // lsb first
            tx_line_q <= tx_sh_q[1];
            tx_bit_q <= tx_bit_q + 3'h1;
          end
        end
        TX_PAR: if (tx_bend) begin
          tx_st_q <= TX_STOP;
          tx_line_q <= 1'b1;
        end
        TX_STOP: if (tx_bend) begin
          tx_st_q <= TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receiver
  rx_state_e rx_st_q;
  logic rx_run_q, rx_prev_q, rx_on, rx_smp, push, pop, perr_q, new_head;
  logic [7:0] rx_sh_q, brk_cnt_q, frame_ticks;
  logic [2:0] rx_bit_q;
  logic [3:0] rx_ovs_q;
  logic [9:0] grace_q;
  assign frame_ticks = 8'((`FRAME_BITS + (par_on ? 1 : 0)) * `OVS);
  assign rx_on = rx_run_q | (grace_q != 10'h0);
  assign rx_smp = tick & (rx_ovs_q == 4'h7);
  assign push = (rx_st_q == RX_STOP) & rx_smp;
  assign pop = rd & (i_paddr == `OFF_RX_DATA) & (rx_cnt_q != 3'h0);

  // run flag and four byte-time grace window after halt
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_run_q <= 1'b0;
      grace_q <= 10'h0;
    end else begin
      rx_run_q <= (rx_run_q | t_brx) & ~t_hrx;
      if (t_hrx && rx_run_q) begin
        grace_q <= 10'(`GRACE_BYTES * frame_ticks);
      end else if (t_brx) begin
        grace_q <= 10'h0;
      end else if (tick && grace_q != 10'h0) begin
        grace_q <= grace_q - 10'h1;
      end
    end
  end

  // frame sequencer, sampling mid-bit on the 16x tick
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_st_q <= RX_IDLE;
      rx_prev_q <= 1'b1;
      rx_sh_q <= 8'h0;
      rx_bit_q <= 3'h0;
      rx_ovs_q <= 4'h0;
      perr_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_in;
      if (tick) begin
        rx_ovs_q <= rx_ovs_q + 4'h1;
      end
      case (rx_st_q)
        // only a falling edge starts a frame, so a held-low break is one frame
        RX_IDLE: if (rx_on && rx_prev_q && !rx_in) begin
          rx_st_q <= RX_START;
          rx_ovs_q <= 4'h0;
          perr_q <= 1'b0;
        end
        RX_START: if (rx_smp) begin
          rx_st_q <= rx_in ? RX_IDLE : RX_DATA;
          rx_bit_q <= 3'h0;
        end
        RX_DATA: if (rx_smp) begin
          rx_sh_q <= {rx_in, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7) begin
            rx_st_q <= par_on ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (rx_smp) begin
          perr_q <= rx_in ^ (^rx_sh_q);
          rx_st_q <= RX_STOP;
        end
        RX_STOP: if (rx_smp) begin
          rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // break detector: counts oversample ticks of low line, fires once past a frame
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      brk_cnt_q <= 8'h0;
    end else if (rx_in) begin
      brk_cnt_q <= 8'h0;
    end else if (tick && brk_cnt_q != 8'hFF) begin
      brk_cnt_q <= brk_cnt_q + 8'h1;
    end
  end

  // the stop bit lands inside the frame, before the break count can expire
  assign err_set.framing = push & ~rx_in;
  assign err_set.brk = tick & ~rx_in & (brk_cnt_q == frame_ticks);
  assign err_set.parity = push & perr_q;
  assign err_set.overrun = push & ~pop & (rx_cnt_q == 3'(`RX_DEPTH));

  // receive fifo storage; no reset, the count alone says which entries are live
  always_ff @(posedge i_mclk) begin
    if (push && err_set.overrun) begin
      rx_mem[(rx_wp_q == 3'h0) ? 3'(`RX_DEPTH - 1) : rx_wp_q - 3'h1] <= rx_sh_q;
    end else if (push) begin
      rx_mem[rx_wp_q] <= rx_sh_q;
    end
  end

  // receive fifo pointers; when full the newest entry is overwritten
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_wp_q <= 3'h0;
      rx_rp_q <= 3'h0;
      rx_cnt_q <= 3'h0;
    end else begin
      if (push && !err_set.overrun) begin
        rx_wp_q <= (rx_wp_q == 3'(`RX_DEPTH - 1)) ? 3'h0 : rx_wp_q + 3'h1;
      end
      if (pop) begin
        rx_rp_q <= (rx_rp_q == 3'(`RX_DEPTH - 1)) ? 3'h0 : rx_rp_q + 3'h1;
      end
      if (push && !pop && !err_set.overrun) begin
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end else if (pop && !push) begin
        rx_cnt_q <= rx_cnt_q - 3'h1;
      end
    end
  end
  // a byte reaches the data register on arrival into an empty fifo or on a pop that leaves a byte held
  assign new_head = (push & (rx_cnt_q == 3'h0)) | (pop & ((rx_cnt_q > 3'h1) | push));

  // request-to-send: drops at two held (room for four), returns only when empty
  logic rts_act_q;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rts_act_q <= 1'b0;
      rts_n_q <= 1'b1;
    end else begin
      if (!rx_run_q || rx_cnt_q >= 3'(`RTS_LIMIT)) begin
        rts_act_q <= 1'b0;
      end else if (rx_cnt_q == 3'h0) begin
        rts_act_q <= 1'b1;
      end
      rts_n_q <= cfg_hwfc_q ? ~rts_act_q : 1'b0;
    end
  end

  // ==========================================================
  // events and error source; a hardware set beats a software clear
  logic ev_clr_rr, ev_clr_td, ev_clr_er, ev_clr_to;
  logic [3:0] err_w1c;
  assign ev_clr_rr = wr & (i_paddr == `OFF_EV_RXRDY) & ~i_pwdata[0];
  assign ev_clr_td = wr & (i_paddr == `OFF_EV_TXDONE) & ~i_pwdata[0];
  assign ev_clr_er = wr & (i_paddr == `OFF_EV_ERROR) & ~i_pwdata[0];
  assign ev_clr_to = wr & (i_paddr == `OFF_EV_RECEIVER_TIMEOUT_EVENT) & ~i_pwdata[0];
  assign err_w1c = (wr && i_paddr == `OFF_ERRSRC) ? i_pwdata[3:0] : 4'h0;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_txdone_q <= 1'b0;
      ev_rxrdy_q <= 1'b0;
      ev_err_q <= 1'b0;
      ev_receiver_timeout_event_q <= 1'b0;
      err_q <= '0;
    end else begin
      ev_txdone_q <= (tx_st_q == TX_STOP && tx_bend && !t_htx) | (ev_txdone_q & ~ev_clr_td);
      ev_rxrdy_q <= new_head | (ev_rxrdy_q & ~ev_clr_rr);
      ev_err_q <= (|err_set) | (ev_err_q & ~ev_clr_er);
      ev_receiver_timeout_event_q <= (tick && grace_q == 10'h1) | (ev_receiver_timeout_event_q & ~ev_clr_to);
      err_q <= err_set | (err_q & ~err_w1c);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_halt_tx; t_htx; endsequence
  sequence s_tx_idle; tx_st_q == TX_IDLE && tx_line_q; endsequence

  psel_disc_a: assert property (
    (psel_tx_q == `PSEL_RESET && psel_rts_q == `PSEL_RESET) |=> &o_pin_oen)
    else $error("pin driven with all selects disconnected");
  psel_enable_a: assert property (
    !en ##1 !en |-> &o_pin_oen) else $error("pin driven while disabled");
  rts_level_a: assert property (
    cfg_hwfc_q && rx_cnt_q >= 3'h2 ##1 cfg_hwfc_q |=> rts_n_q) else $error("request-to-send not inactive");
  tx_begin_a: assert property (
    tx_st_q == TX_IDLE && tx_go && !t_htx |=> !tx_line_q && tx_st_q == TX_START)
    else $error("frame did not start");
  tx_done_a: assert property (
    tx_st_q == TX_STOP && tx_bend && !t_htx |=> ev_txdone_q && tx_st_q == TX_IDLE)
    else $error("transmit-done missing");
  tx_halt_a: assert property (
    s_halt_tx |=> s_tx_idle) else $error("halt did not stop transmitter");
  cts_pause_a: assert property (
    cfg_hwfc_q && cts_n && tx_st_q == TX_IDLE |=> tx_st_q == TX_IDLE) else $error("sent while paused");
  rx_again_a: assert property (
    pop && rx_cnt_q > 3'h1 |=> ev_rxrdy_q) else $error("receive-ready not raised again");
  rx_timeout_a: assert property (
    tick && grace_q == 10'h1 |=> ev_receiver_timeout_event_q && !rx_on) else $error("timeout event missing");
  brk_order_a: assert property (
    err_set.brk |-> rx_st_q != RX_STOP) else $error("break before framing");
endmodule : uart_fc

// [uart_fc_defs.svh]
`ifndef UART_FC_DEFS_SVH
`define UART_FC_DEFS_SVH
// ==========================================================
// register byte offsets
`define OFF_BEGIN_RX 12'h000
`define OFF_HALT_RX 12'h004
`define OFF_BEGIN_TX 12'h008
`define OFF_HALT_TX 12'h00C
`define OFF_EV_RXRDY 12'h108
`define OFF_EV_TXDONE 12'h11C
`define OFF_EV_ERROR 12'h124
`define OFF_EV_RECEIVER_TIMEOUT_EVENT 12'h144
`define OFF_ERRSRC 12'h480
`define OFF_ENABLE 12'h500
`define OFF_PSEL_RTS 12'h508
`define OFF_PSEL_TX 12'h50C
`define OFF_PSEL_CTS 12'h510
`define OFF_PSEL_RX 12'h514
`define OFF_RX_DATA 12'h518
`define OFF_TX_DATA 12'h51C
`define OFF_BAUD 12'h524
`define OFF_CONFIG 12'h56C
// ==========================================================
// field values and reset values
`define ENABLE_ON 3'h4
`define PARITY_ON 3'h7
`define PSEL_RESET 32'hFFFFFFFF
`define BAUD_RESET 32'h04000000
// ==========================================================
// timing: baud setting is a fraction of a 16 MHz reference, clock is 40 MHz
`define REF_HZ 16000000
`define CLK_HZ 40000000
`define BAUD_SCALE 16'h6666
`define OVS 16
`define FRAME_BITS 10
`define GRACE_BYTES 4
`define RX_DEPTH 6
`define RTS_LIMIT 2
`endif

// [uart_fc_pkg.sv]
package uart_fc_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_e;
  // error source flags, bit 3 downward
  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } err_s;
endpackage : uart_fc_pkg

// [uart_remote_model.sv]
// ==========================================================
// remote serial end: samples the device line, sends frames
module uart_remote_model #(
  parameter int BIT_CLKS = 40
) (
  input wire logic i_mclk,
  input wire logic i_rts_n,
  input wire logic i_line,
  input wire logic i_par_en,
  output logic o_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got_q[$];
  logic [8:0] w;
  initial o_line = 1'b1;
  // mid-bit sampling, lsb first, parity kept as bit 8
  initial begin
    forever begin
      @(negedge i_line);
      repeat (BIT_CLKS / 2) @(posedge i_mclk);
      w = 9'h000;
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CLKS) @(posedge i_mclk);
        if (i < 8 || i_par_en) w[i] = i_line;
      end
      got_q.push_back(w);
    end
  end
  // holds off while request-to-send is high, i.e. inactive
  task automatic send(input logic [7:0] b, input logic bad_par, input logic stop);
    logic [10:0] f;
    int n;
    f = {stop, ^b ^ bad_par, b, 1'b0};
    if (!i_par_en) f = {1'b1, stop, b, 1'b0};
    for (n = 0; i_rts_n && n < 20000; n++) @(posedge i_mclk);
    // a hold-off that never ends is a hang, so it counts as a mismatch
    if (i_rts_n) tb_uart_flow_control_serial_port.fail();
    for (int i = 0; i < (i_par_en ? 11 : 10); i++) begin
      o_line <= f[i];
      repeat (BIT_CLKS) @(posedge i_mclk);
    end
    o_line <= 1'b1;
    // one idle clock, so a following call never drives the line twice in one step
    @(posedge i_mclk);
  endtask : send
  // a long low level, as a line break looks
  task automatic hold_low(input int n);
    o_line <= 1'b0;
    repeat (n) @(posedge i_mclk);
    o_line <= 1'b1;
  endtask : hold_low
endmodule : uart_remote_model

// [tb_uart_flow_control_serial_port.sv]
`include "uart_fc_defs.svh"
module tb_uart_flow_control_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] v;} row_s;
  // ==========================================================
  // signals
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready;
  logic pslverr;
  logic [31:0] prdata, pin_out, pin_oen, q;
  logic err;
  logic cts_n = 1'b0;
  logic par_en = 1'b0;
  logic rx_line;
  int bad_count = 0;
  int samples_checked = 0;
  // undriven pins are pulled up
  wire tx_wire = pin_oen[1] ? 1'b1 : pin_out[1];
  wire rts_wire = pin_oen[3] ? 1'b1 : pin_out[3];
  wire [31:0] pins = {28'hFFFFFFF, rts_wire, cts_n, tx_wire, rx_line};
  row_s rows[10] = '{'{`OFF_ENABLE, 32'h0}, '{`OFF_CONFIG, 32'h0}, '{`OFF_BAUD, `BAUD_RESET},
    '{`OFF_PSEL_RTS, `PSEL_RESET}, '{`OFF_PSEL_TX, `PSEL_RESET}, '{`OFF_PSEL_CTS, `PSEL_RESET},
    '{`OFF_PSEL_RX, `PSEL_RESET}, '{`OFF_EV_RXRDY, 32'h0}, '{`OFF_ERRSRC, 32'h0}, '{12'h600, 32'h0}};
  uart_fc u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_pin(pins), .o_pin(pin_out), .o_pin_oen(pin_oen));
  uart_remote_model u_far (.i_mclk(i_mclk), .i_rts_n(rts_wire), .i_line(tx_wire), .i_par_en(par_en),
    .o_line(rx_line));
  // 40 MHz clock
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  // ==========================================================
  // tasks
  task automatic summarize;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  task automatic fail;
    bad_count++;
    summarize();
  endtask : fail
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1) fail();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_mclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // polls a flag; a bounded wait, so a hang ends the run
  task automatic wait_set(input logic [11:0] a, input logic [31:0] m);
    int n;
    q = 32'h0;
    for (n = 0; n < 500 && (q & m) !== m; n++) rd(a);
    if ((q & m) !== m) fail();
  endtask : wait_set
  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
    foreach (rows[i]) begin
      rd(rows[i].a);
      check("reset register", rows[i].v, q);
    end
    check("unmapped error", 32'h1, {31'h0, err});
    // pins routed while disabled stay undriven
    wr(`OFF_PSEL_RX, 32'h0);
    wr(`OFF_PSEL_TX, 32'h1);
    wr(`OFF_PSEL_CTS, 32'h2);
    wr(`OFF_PSEL_RTS, 32'h3);
    wr(`OFF_BAUD, 32'h10000000);
    repeat (4) @(posedge i_mclk);
    check("disabled enables", 32'hFFFFFFFF, pin_oen);
    wr(`OFF_ENABLE, {29'h0, `ENABLE_ON});
    repeat (4) @(posedge i_mclk);
    check("enabled enables", 32'hFFFFFFF5, pin_oen);
    check("free rts", 32'h0, {31'h0, rts_wire});
    // a frame without and with parity
    for (int p = 0; p < 2; p++) begin
      par_en <= p[0];
      wr(`OFF_CONFIG, p[0] ? 32'hE : 32'h0);
      wr(`OFF_BEGIN_TX, 32'h1);
      wr(`OFF_TX_DATA, p[0] ? 32'h07 : 32'hA5);
      wait_set(`OFF_EV_TXDONE, 32'h1);
      wr(`OFF_EV_TXDONE, 32'h0);
      check("sent frame", p[0] ? 32'h107 : 32'h0A5, {23'h0, u_far.got_q.pop_front()});
    end
    // inactive clear-to-send stalls, a frame in flight still ends
    par_en <= 1'b0;
    wr(`OFF_CONFIG, 32'h1);
    cts_n <= 1'b1;
    wr(`OFF_TX_DATA, 32'h3C);
    repeat (800) @(posedge i_mclk);
    check("stalled frames", 32'h0, u_far.got_q.size());
    cts_n <= 1'b0;
    wait_set(`OFF_EV_TXDONE, 32'h1);
    wr(`OFF_EV_TXDONE, 32'h0);
    check("resumed frame", 32'h3C, {23'h0, u_far.got_q.pop_front()});
    wr(`OFF_TX_DATA, 32'h5A);
    repeat (100) @(posedge i_mclk);
    cts_n <= 1'b1;
    wait_set(`OFF_EV_TXDONE, 32'h1);
    wr(`OFF_EV_TXDONE, 32'h0);
    check("finished frame", 32'h5A, {23'h0, u_far.got_q.pop_front()});
    cts_n <= 1'b0;
    // halt in mid-frame: line back high, no done event
    wr(`OFF_TX_DATA, 32'h00);
    repeat (150) @(posedge i_mclk);
    wr(`OFF_HALT_TX, 32'h1);
    repeat (2) @(posedge i_mclk);
    check("halted line", 32'h1, {31'h0, tx_wire});
    repeat (600) @(posedge i_mclk);
    rd(`OFF_EV_TXDONE);
    check("halted done", 32'h0, q);
    u_far.got_q.delete();
    // two bytes close request-to-send until the fifo is empty
    wr(`OFF_BEGIN_RX, 32'h1);
    repeat (4) @(posedge i_mclk);
    check("rts open", 32'h0, {31'h0, rts_wire});
    u_far.send(8'h11, 1'b0, 1'b1);
    u_far.send(8'h22, 1'b0, 1'b1);
    repeat (20) @(posedge i_mclk);
    check("rts closed", 32'h1, {31'h0, rts_wire});
    for (int i = 0; i < 2; i++) begin
      wait_set(`OFF_EV_RXRDY, 32'h1);
      wr(`OFF_EV_RXRDY, 32'h0);
      rd(`OFF_RX_DATA);
      check("received byte", 32'h11 * (i + 1), q);
      if (i == 0) begin
        rd(`OFF_EV_RXRDY);
        check("ready again", 32'h1, q);
        check("rts still closed", 32'h1, {31'h0, rts_wire});
      end
    end
    repeat (4) @(posedge i_mclk);
    check("rts reopened", 32'h0, {31'h0, rts_wire});
    // halt receive: rts drops, timeout after four frame times
    wr(`OFF_HALT_RX, 32'h1);
    repeat (4) @(posedge i_mclk);
    check("rts halted", 32'h1, {31'h0, rts_wire});
    repeat (1400) @(posedge i_mclk);
    rd(`OFF_EV_RECEIVER_TIMEOUT_EVENT);
    check("early timeout", 32'h0, q);
    wait_set(`OFF_EV_RECEIVER_TIMEOUT_EVENT, 32'h1);
    // bad stop bit, then a break, then bad parity
    wr(`OFF_BEGIN_RX, 32'h1);
    wr(`OFF_CONFIG, 32'h0);
    u_far.send(8'hFF, 1'b0, 1'b0);
    wait_set(`OFF_EV_ERROR, 32'h1);
    rd(`OFF_ERRSRC);
    check("framing flag", 32'h4, q);
    wr(`OFF_ERRSRC, 32'hF);
    wr(`OFF_EV_ERROR, 32'h0);
    u_far.hold_low(1200);
    wait_set(`OFF_EV_ERROR, 32'h1);
    rd(`OFF_ERRSRC);
    check("break flags", 32'hC, q);
    wr(`OFF_ERRSRC, 32'hF);
    par_en <= 1'b1;
    wr(`OFF_CONFIG, 32'hE);
    u_far.send(8'h03, 1'b1, 1'b1);
    repeat (20) @(posedge i_mclk);
    rd(`OFF_ERRSRC);
    check("parity flag", 32'h2, q & 32'hE);
    // three bytes are held; four more fill the fifo and overwrite once
    for (int i = 0; i < 4; i++) begin
      u_far.send(8'h40 + 8'(i), 1'b0, 1'b1);
    end
    repeat (20) @(posedge i_mclk);
    rd(`OFF_ERRSRC);
    check("overrun flag", 32'h1, q & 32'h1);
    summarize();
  end
endmodule : tb_uart_flow_control_serial_port
